// [verilog/spmc_pkg.sv]
// constants for the serial port modem control block
package spmc_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // register byte addresses
  localparam logic [7:0] OFS_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] OFS_MODEM_STATUS = 8'h04;
  localparam logic [7:0] OFS_STRAP = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h10;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h14;

  // modem control fields
  localparam int unsigned CTL_W = 5;
  localparam int unsigned CTL_TERM_READY = 0;
  localparam int unsigned CTL_REQ_SEND = 1;
  localparam int unsigned CTL_AUX1 = 2;
  localparam int unsigned CTL_AUX2 = 3;
  localparam int unsigned CTL_LOOPBACK = 4;
  localparam logic [4:0] CTL_RESET = 5'h00;

  // modem status fields, 1 means asserted
  localparam int unsigned STS_W = 4;
  localparam int unsigned STS_CLEAR_TO_SEND = 0;
  localparam int unsigned STS_DATA_SET_READY = 1;
  localparam int unsigned STS_RING = 2;
  localparam int unsigned STS_CARRIER = 3;
  localparam logic [3:0] STS_RESET = 4'h0;

  // interrupt layout: same bit order as modem status
  localparam int unsigned INT_W = 4;
  localparam logic [3:0] INT_RESET = 4'h0;

  // strap capture fields
  localparam int unsigned STRAP_W = 3;
  localparam int unsigned STRAP_A = 0;
  localparam int unsigned STRAP_B = 1;
  localparam int unsigned STRAP_C = 2;
  localparam logic [2:0] STRAP_RESET = 3'h0;

  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

// [verilog/spmc_modem_ctrl.sv]
// modem control and status pins of serial port one, with apb registers
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - low carrier detect means carrier present; readable in modem status register.
// - low ring indicate means ring received; readable in modem status register.
// - low clear-to-send means partner accepts data; shown in modem status register.
// - low data-set-ready means partner ready for link; shown in status register.
// - terminal-ready output driven low while its control bit is 1.
// - request-to-send output driven low while its control bit is 1.
// - both outputs held high after master reset and during loopback.
// - serial transmit output forced to marking level 1 after master reset.
// - during host bus reset, three pins released and read as strap inputs.
//
// The APB register port and the address map were decided locally.
module spmc_modem_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lreset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic carrier_detect_n,
  input wire logic ring_indicate_n,
  input wire logic clear_to_send_n,
  input wire logic data_set_ready_n,
  output logic terminal_ready_n,
  output logic terminal_ready_n_oe,
  input wire logic terminal_ready_n_in,
  output logic request_to_send_n,
  output logic request_to_send_n_oe,
  input wire logic request_to_send_n_in,
  input wire logic tx_serial_data,
  output logic serial_tx_out,
  output logic serial_tx_out_oe,
  input wire logic serial_tx_out_in,
  output logic strap_option_a,
  output logic strap_option_b,
  output logic strap_option_c,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic [4:0] modem_control_reg;
  logic [3:0] modem_status_reg;
  logic [3:0] modem_status_next;
  logic [3:0] pin_status;
  logic [3:0] loop_status;
  logic [3:0] int_status_reg;
  logic [3:0] int_status_next;
  logic [3:0] int_enable_reg;
  logic [3:0] events;
  logic [2:0] strap_reg;
  logic lreset_q_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] read_word;
  logic irq_reg;
  logic term_ready_n_reg;
  logic req_send_n_reg;
  logic tx_out_reg;
  logic pins_oe_reg;
  logic access;
  logic wait_phase;
  logic wr_commit;
  logic wr_control;
  logic wr_enable;
  logic wr_clear;
  logic loopback;
  logic strap_window;

  // change detect: level changes on three inputs, ring only when it ends
  function automatic logic [3:0] spmc_events(input logic [3:0] prev, input logic [3:0] cur);
    logic [3:0] ev;
    ev = prev ^ cur;
    ev[spmc_pkg::STS_RING] = prev[spmc_pkg::STS_RING] & ~cur[spmc_pkg::STS_RING];
    return ev;
  endfunction

  // address decode for the error answer; the read mux decodes with its own case
  function automatic logic spmc_mapped(input logic [7:0] a);
    return (a == spmc_pkg::OFS_MODEM_CONTROL) || (a == spmc_pkg::OFS_MODEM_STATUS) ||
           (a == spmc_pkg::OFS_STRAP) || (a == spmc_pkg::OFS_INT_STATUS) ||
           (a == spmc_pkg::OFS_INT_ENABLE) || (a == spmc_pkg::OFS_INT_CLEAR);
  endfunction

  // active low handshake, held idle in loopback so the modem sees no self test
  function automatic logic spmc_handshake_n(input logic ctl_bit, input logic loop);
    return ~(ctl_bit & ~loop);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb begin
    read_word = spmc_pkg::DATA_ZERO;
    case (paddr)
      spmc_pkg::OFS_MODEM_CONTROL: read_word = {27'h0, modem_control_reg};
      spmc_pkg::OFS_MODEM_STATUS: read_word = {28'h0, modem_status_reg};
      spmc_pkg::OFS_STRAP: read_word = {29'h0, strap_reg};
      spmc_pkg::OFS_INT_STATUS: read_word = {28'h0, int_status_reg};
      spmc_pkg::OFS_INT_ENABLE: read_word = {28'h0, int_enable_reg};
      default: read_word = spmc_pkg::DATA_ZERO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, pready from a flip-flop

  assign access = psel & penable;
  assign wait_phase = access & ~pready_reg;
  assign wr_commit = access & pready_reg & pwrite;
  assign wr_control = wr_commit & (paddr == spmc_pkg::OFS_MODEM_CONTROL);
  assign wr_enable = wr_commit & (paddr == spmc_pkg::OFS_INT_ENABLE);
  assign wr_clear = wr_commit & (paddr == spmc_pkg::OFS_INT_CLEAR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= wait_phase;
    end
  end

  // refusal decided in the wait cycle so it stands together with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= wait_phase & ~spmc_mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= spmc_pkg::DATA_ZERO;
    end else if (wait_phase && !pwrite) begin
      prdata_reg <= read_word;
    end else begin
      prdata_reg <= spmc_pkg::DATA_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // modem control and interrupt enable registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_control_reg <= spmc_pkg::CTL_RESET;
    end else if (wr_control) begin
      modem_control_reg <= pwdata[spmc_pkg::CTL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_enable_reg <= spmc_pkg::INT_RESET;
    end else if (wr_enable) begin
      int_enable_reg <= pwdata[spmc_pkg::INT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // modem status

  assign loopback = modem_control_reg[spmc_pkg::CTL_LOOPBACK];

  // pins are active low; a status bit reads 1 for an asserted condition
  always_comb begin
    pin_status[spmc_pkg::STS_CLEAR_TO_SEND] = ~clear_to_send_n;
    pin_status[spmc_pkg::STS_DATA_SET_READY] = ~data_set_ready_n;
    pin_status[spmc_pkg::STS_RING] = ~ring_indicate_n;
    pin_status[spmc_pkg::STS_CARRIER] = ~carrier_detect_n;
  end

  // self test: handshakes come back from the control bits, not the modem
  always_comb begin
    loop_status[spmc_pkg::STS_CLEAR_TO_SEND] = modem_control_reg[spmc_pkg::CTL_REQ_SEND];
    loop_status[spmc_pkg::STS_DATA_SET_READY] = modem_control_reg[spmc_pkg::CTL_TERM_READY];
    loop_status[spmc_pkg::STS_RING] = modem_control_reg[spmc_pkg::CTL_AUX1];
    loop_status[spmc_pkg::STS_CARRIER] = modem_control_reg[spmc_pkg::CTL_AUX2];
  end

  assign modem_status_next = loopback ? loop_status : pin_status;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_status_reg <= spmc_pkg::STS_RESET;
    end else begin
      modem_status_reg <= modem_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, new event wins over a clear in the same cycle

  assign events = spmc_events(modem_status_reg, modem_status_next);

  always_comb begin
    int_status_next = int_status_reg;
    if (wr_clear) begin
      int_status_next = int_status_next & ~pwdata[spmc_pkg::INT_W-1:0];
    end
    int_status_next = int_status_next | events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_reg <= spmc_pkg::INT_RESET;
    end else begin
      int_status_reg <= int_status_next;
    end
  end

  // built from the next status so irq rises on the same edge as its bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_status_next & int_enable_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      term_ready_n_reg <= 1'b1;
    end else begin
      term_ready_n_reg <= spmc_handshake_n(modem_control_reg[spmc_pkg::CTL_TERM_READY], loopback);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_send_n_reg <= 1'b1;
    end else begin
      req_send_n_reg <= spmc_handshake_n(modem_control_reg[spmc_pkg::CTL_REQ_SEND], loopback);
    end
  end

  // line held marking in loopback so the far end sees no self-test traffic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out_reg <= 1'b1;
    end else begin
      tx_out_reg <= tx_serial_data | loopback;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // straps: pins released while the host bus reset is low

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lreset_q_reg <= 1'b0;
    end else begin
      lreset_q_reg <= lreset_n;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_oe_reg <= 1'b0;
    end else begin
      pins_oe_reg <= lreset_n;
    end
  end

  // enables lag lreset_n by one edge, so the pins are still released when sampled
  assign strap_window = lreset_n & ~lreset_q_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_reg <= spmc_pkg::STRAP_RESET;
    end else if (strap_window) begin
      strap_reg[spmc_pkg::STRAP_A] <= terminal_ready_n_in;
      strap_reg[spmc_pkg::STRAP_B] <= request_to_send_n_in;
      strap_reg[spmc_pkg::STRAP_C] <= serial_tx_out_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign terminal_ready_n = term_ready_n_reg;
  assign request_to_send_n = req_send_n_reg;
  assign serial_tx_out = tx_out_reg;
  assign terminal_ready_n_oe = pins_oe_reg;
  assign request_to_send_n_oe = pins_oe_reg;
  assign serial_tx_out_oe = pins_oe_reg;
  assign strap_option_a = strap_reg[spmc_pkg::STRAP_A];
  assign strap_option_b = strap_reg[spmc_pkg::STRAP_B];
  assign strap_option_c = strap_reg[spmc_pkg::STRAP_C];
  assign irq = irq_reg;

endmodule

// [test/spmc_checker.sv]
// concurrent checks on the modem control block ports
module spmc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lreset_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic terminal_ready_n,
  input wire logic terminal_ready_n_oe,
  input wire logic request_to_send_n,
  input wire logic request_to_send_n_oe,
  input wire logic serial_tx_out,
  input wire logic serial_tx_out_oe,
  input wire logic strap_option_a,
  input wire logic strap_option_b,
  input wire logic strap_option_c
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_ctl_wr;
    s_done ##0 pwrite && paddr == spmc_pkg::OFS_MODEM_CONTROL;
  endsequence
  a_one_wait: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("ready not after one wait state");
  a_unmapped_err: assert property (s_done ##0 paddr > 8'h14 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_dtr_on: assert property (s_ctl_wr ##0 pwdata[0] && !pwdata[4] |-> ##[1:2] !terminal_ready_n)
    else $error("terminal ready not driven low");
  a_rts_on: assert property (s_ctl_wr ##0 pwdata[1] && !pwdata[4] |-> ##[1:2] !request_to_send_n)
    else $error("request to send not driven low");
  a_loop_idle: assert property (s_ctl_wr ##0 pwdata[4] |-> ##2 terminal_ready_n && request_to_send_n)
    else $error("outputs active in loopback");
  a_reset_idle: assert property ($rose(presetn) |-> terminal_ready_n && request_to_send_n && serial_tx_out)
    else $error("outputs not idle after reset");
  a_strap_release: assert property (!lreset_n |=> !terminal_ready_n_oe && !request_to_send_n_oe && !serial_tx_out_oe)
    else $error("pin driven during host reset");
  a_drive_back: assert property (lreset_n [*2] |-> terminal_ready_n_oe && request_to_send_n_oe && serial_tx_out_oe)
    else $error("pin not driven after host reset");
  a_strap_hold: assert property (!$rose(lreset_n) |=> $stable({strap_option_c, strap_option_b, strap_option_a}))
    else $error("strap levels changed");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind spmc_modem_ctrl spmc_checker i_spmc_checker (
  .pclk(pclk),
  .presetn(presetn),
  .lreset_n(lreset_n),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .terminal_ready_n(terminal_ready_n),
  .terminal_ready_n_oe(terminal_ready_n_oe),
  .request_to_send_n(request_to_send_n),
  .request_to_send_n_oe(request_to_send_n_oe),
  .serial_tx_out(serial_tx_out),
  .serial_tx_out_oe(serial_tx_out_oe),
  .strap_option_a(strap_option_a),
  .strap_option_b(strap_option_b),
  .strap_option_c(strap_option_c)
);

// [test/spmc_modem_model.sv]
// far-side modem: ready lines answer the requests after a lag
module spmc_modem_model #(
  parameter int LAG = 4
) (
  input wire logic pclk,
  input wire logic terminal_ready_n_in,
  input wire logic request_to_send_n_in,
  input wire logic [1:0] line_n,
  output logic carrier_detect_n,
  output logic ring_indicate_n,
  output logic clear_to_send_n,
  output logic data_set_ready_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] dsr_q = 8'hff;
  logic [7:0] cts_q = 8'hff;
  // a slow modem: it sees the wire, so strap levels leak through during host reset
  always_ff @(posedge pclk) begin
    dsr_q <= {dsr_q[6:0], terminal_ready_n_in};
    cts_q <= {cts_q[6:0], request_to_send_n_in};
  end
  assign data_set_ready_n = dsr_q[LAG-1];
  assign clear_to_send_n = cts_q[LAG-1];
  assign {carrier_detect_n, ring_indicate_n} = line_n;
endmodule

// [test/tb_spmc_modem_ctrl.sv]
// self-checking bench for the modem control block
module tb_spmc_modem_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, lreset_n = 0, psel = 0, penable = 0, pwrite = 0, tx_serial_data = 1, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h0caa;
  logic pready, pslverr, irq, carrier_detect_n, ring_indicate_n, clear_to_send_n, data_set_ready_n;
  logic terminal_ready_n, terminal_ready_n_oe, request_to_send_n, request_to_send_n_oe, serial_tx_out;
  logic serial_tx_out_oe, strap_option_a, strap_option_b, strap_option_c;
  logic [3:0] v;
  logic [1:0] line_n = 2'h3;
  logic [2:0] strap = 3'h5;
  int err_count = 0, checks_done = 0, cyc = 0;
  // released pins fall back to the strap resistors
  wire terminal_ready_n_in = terminal_ready_n_oe ? terminal_ready_n : strap[0];
  wire request_to_send_n_in = request_to_send_n_oe ? request_to_send_n : strap[1];
  wire serial_tx_out_in = serial_tx_out_oe ? serial_tx_out : strap[2];
  wire [2:0] pins = {terminal_ready_n, request_to_send_n, serial_tx_out};
  wire [2:0] oes = {terminal_ready_n_oe, request_to_send_n_oe, serial_tx_out_oe};
  wire [2:0] straps = {strap_option_c, strap_option_b, strap_option_a};
  always #10 pclk = ~pclk;
  spmc_modem_ctrl i_spmc_modem_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .lreset_n(lreset_n),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .carrier_detect_n(carrier_detect_n),
    .ring_indicate_n(ring_indicate_n),
    .clear_to_send_n(clear_to_send_n),
    .data_set_ready_n(data_set_ready_n),
    .terminal_ready_n(terminal_ready_n),
    .terminal_ready_n_oe(terminal_ready_n_oe),
    .terminal_ready_n_in(terminal_ready_n_in),
    .request_to_send_n(request_to_send_n),
    .request_to_send_n_oe(request_to_send_n_oe),
    .request_to_send_n_in(request_to_send_n_in),
    .tx_serial_data(tx_serial_data),
    .serial_tx_out(serial_tx_out),
    .serial_tx_out_oe(serial_tx_out_oe),
    .serial_tx_out_in(serial_tx_out_in),
    .strap_option_a(strap_option_a),
    .strap_option_b(strap_option_b),
    .strap_option_c(strap_option_c),
    .irq(irq)
  );
  spmc_modem_model i_spmc_modem_model (
    .pclk(pclk),
    .terminal_ready_n_in(terminal_ready_n_in),
    .request_to_send_n_in(request_to_send_n_in),
    .line_n(line_n),
    .carrier_detect_n(carrier_detect_n),
    .ring_indicate_n(ring_indicate_n),
    .clear_to_send_n(clear_to_send_n),
    .data_set_ready_n(data_set_ready_n)
  );
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // modem answers dtr with dsr and rts with cts
  function automatic logic [31:0] status_exp(logic [1:0] ln, logic [1:0] ctl);
    return {28'h0, ~ln, ctl[0], ctl[1]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task end_of_test;
    $display("mismatches %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge pclk);
    chk({pins, oes}, 6'h38);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({pins, oes}, 6'h38);
    lreset_n <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, spmc_pkg::OFS_STRAP, 32'h0);
    chk({rd[25:0], straps, oes}, {23'h0, strap, strap, 3'h7});
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      v = (i == 0) ? 4'h3 : (i == 1) ? 4'h0 : rnd[3:0];
      line_n <= rnd[5:4];
      tx_serial_data <= rnd[6];
      apb(1'b1, spmc_pkg::OFS_MODEM_CONTROL, {28'h0, v});
      repeat (8) @(posedge pclk);
      chk(pins, {~v[0], ~v[1], rnd[6]});
      apb(1'b0, spmc_pkg::OFS_MODEM_STATUS, 32'h0);
      chk(rd, status_exp(line_n, v[1:0]));
    end
    tx_serial_data <= 1'b0;
    apb(1'b1, spmc_pkg::OFS_MODEM_CONTROL, 32'h1d);
    repeat (3) @(posedge pclk);
    apb(1'b0, spmc_pkg::OFS_MODEM_STATUS, 32'h0);
    chk({pins, rd[3:0]}, 7'h7e);
    apb(1'b1, spmc_pkg::OFS_MODEM_CONTROL, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b1, spmc_pkg::OFS_INT_CLEAR, 32'hf);
    apb(1'b1, spmc_pkg::OFS_INT_ENABLE, 32'h8);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    line_n[1] <= ~line_n[1];
    repeat (3) @(posedge pclk);
    apb(1'b0, spmc_pkg::OFS_INT_STATUS, 32'h0);
    chk({irq, rd[3]}, 2'h3);
    apb(1'b1, spmc_pkg::OFS_INT_CLEAR, 32'h8);
    apb(1'b1, spmc_pkg::OFS_INT_ENABLE, 32'h0);
    line_n[1] <= ~line_n[1];
    repeat (3) @(posedge pclk);
    apb(1'b0, spmc_pkg::OFS_INT_STATUS, 32'h0);
    chk({irq, rd[3]}, 2'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    lreset_n <= 1'b0;
    strap <= ~strap;
    repeat (3) @(posedge pclk);
    chk({oes, straps}, {3'h0, ~strap});
    lreset_n <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b0, spmc_pkg::OFS_STRAP, 32'h0);
    chk(rd, {29'h0, strap});
    end_of_test();
  end
endmodule
